// ---- rtl/tpw_pkg.sv ----
/*
 * tpw_pkg: register map, field positions, reset values and bus carrier
 * of the three-phase pwm output stage.
 * assumes a single ahb-lite master and word-wide register accesses.
 */
package tpw_pkg;

	// register byte offsets (haddr[7:0])
	localparam logic [7:0] TPW_A_CTRL = 8'h00;
	localparam logic [7:0] TPW_A_OUTL = 8'h04;
	localparam logic [7:0] TPW_A_PSEL = 8'h08;
	localparam logic [7:0] TPW_A_PROT = 8'h0C;
	localparam logic [7:0] TPW_A_CARR = 8'h10;
	localparam logic [7:0] TPW_A_WIDU = 8'h14;
	localparam logic [7:0] TPW_A_WIDV = 8'h18;
	localparam logic [7:0] TPW_A_WIDW = 8'h1C;
	localparam logic [7:0] TPW_A_IRQF = 8'h20;
	localparam logic [7:0] TPW_A_STAT = 8'h24;

	// control register bit positions
	localparam int TPW_B_MTF  = 0;
	localparam int TPW_B_OE   = 1;
	localparam int TPW_B_CPS  = 2;
	localparam int TPW_B_CDF  = 3;
	localparam int TPW_B_ALS  = 4;
	localparam int TPW_B_POL  = 5;
	localparam int TPW_B_FCE  = 6;
	localparam int TPW_B_NMIE = 7;
	localparam int TPW_B_RUN  = 8;
	localparam int TPW_B_FLT  = 9;

	// second output logic field position in the output logic register
	localparam int TPW_B_OUTL2 = 8;

	// values after reset
	localparam logic [5:0]  TPW_PFC_RST  = 6'h3F;
	localparam logic [5:0]  TPW_OUTL_RST = 6'h3F;
	localparam logic [15:0] TPW_CARR_RST = 16'hFFFF;
	localparam logic [15:0] TPW_WID_RST  = 16'h0001;
	localparam logic        TPW_SD_RST   = 1'b1;

	// consecutive equal samples before the shutdown level passes
	localparam logic [1:0] TPW_FLT_RUN = 2'h3;

	// ahb-lite address phase signals
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} tpw_ahb_req_t;

endpackage : tpw_pkg

// ---- rtl/tpw_sd_filter.sv ----
/*
 * tpw_sd_filter: synchroniser and three-sample digital filter for the
 * shutdown input.
 * assumes the pin is asynchronous to sys_clk_i; idle level is high.
 */
`timescale 1ns/1ps
module tpw_sd_filter
	import tpw_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	// pin and setting
	input  wire logic       sd_pin_i,
	input  wire logic [2:0] setting_i,
	// filtered level
	output logic            level_o
);
	logic       sync1;
	logic       sync2;
	logic [6:0] div;
	logic       last;
	logic [1:0] run;
	logic       tick;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1 <= TPW_SD_RST;
			sync2 <= TPW_SD_RST;
		end else begin
			sync1 <= sd_pin_i;
			sync2 <= sync1;
		end
	end

	// sampling clock is sys_clk divided by 2 to the setting
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			div <= 7'h00;
		else
			div <= div + 7'h01;
	end
	assign tick = ((div & ((7'h01 << setting_i) - 7'h01)) == 7'h00);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last    <= TPW_SD_RST;
			run     <= TPW_FLT_RUN;
			level_o <= TPW_SD_RST;
		end else if (setting_i == 3'h0) begin
			// keep history in step so a later switch starts from the true level
			last    <= sync2;
			run     <= TPW_FLT_RUN;
			level_o <= sync2;
		end else if (tick) begin
			last <= sync2;
			if (sync2 != last) begin
				run <= 2'h1;
			end else if (run != TPW_FLT_RUN) begin
				run <= run + 2'h1;
				if (run + 2'h1 == TPW_FLT_RUN)
					level_o <= sync2; // see (R10)
			end
		end
	end

endmodule : tpw_sd_filter

// ---- rtl/tpw_oneshot.sv ----
/*
 * tpw_oneshot: phase timer of mode 0, reloads its width on each start
 * trigger and pulses done at the end of the one-shot.
 * assumes trig_i and width_i come from logic on sys_clk_i.
 */
`timescale 1ns/1ps
module tpw_oneshot #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         arst_n_i,
	// start and width
	input  wire logic         trig_i,
	input  wire logic [W-1:0] width_i,
	// end of pulse
	output logic              done_o
);
	logic [W-1:0] cnt;
	logic         busy;

	// a width of zero is out of range and runs as one
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt    <= '0;
			busy   <= 1'b0;
			done_o <= 1'b0;
		end else if (trig_i) begin
			cnt    <= (width_i == '0) ? W'(1) : width_i; // see (R18)
			busy   <= 1'b1;
			done_o <= 1'b0;
		end else if (busy && cnt == W'(1)) begin
			busy   <= 1'b0;
			done_o <= 1'b1;
		end else begin
			cnt    <= busy ? cnt - W'(1) : cnt;
			done_o <= 1'b0;
		end
	end

endmodule : tpw_oneshot

// ---- rtl/tpw_pwm_top.sv ----
/*
 * tpw_pwm_top: three-phase pwm output stage, protection and mode 0
 * carrier, reached as an ahb-lite slave.
 * assumes sd_pin_i and pos_pin_i are asynchronous pins; port_* come from
 * the port logic on sys_clk_i. pin order: U, U-low, V, V-low, W, W-low.
 */
// Functional notes
// (R01) output logic 0 is active; pin level follows active-level select
// (R02) simultaneous high/low activity clears enable, sets flag, floats pins
// (R03) pwm on a pin needs function bit, output enable and pin select
// (R04) six pin selects choose pwm or port independently
// (R05) pin select register writes land only while protect bit is 1
// (R06) software sets protect, rewrites pin select, then clears protect
// (R07) filtered shutdown low clears output enable while function enabled
// (R08) cutoff floats pins when enabled, else pins return to port
// (R09) enabled cutoff floats pins even when assigned to port use
// (R10) shutdown filter passes a level after three equal samples
// (R11) recovery: shutdown high, wait, set enable until read 1, toggle cutoff
// (R12) unused cutoff: shutdown pin as input and held high on board
// (R13) shutdown shares nmi; nmi request only when its enable bit is 1
// (R14) each phase captures its position input on high-side edges
// (R15) one polarity bit selects capture edge for all phases
// (R16) polarity encoding reverses under active-high outputs
// (R17) carrier half period is m+1 source clocks
// (R18) phase timers reload only the primary width per trigger
// (R19) interrupt request every nth carrier underflow
// (R20) software keeps reload timing, modulation and mode bits at 0
// (R21) carrier half flag reads zero in mode 0
// (R22) software sets one-shot phase timers and plain carrier timer
// (R23) software routes carrier trigger to the three phase timers
// (R24) setting output enable is refused during cutoff or conduction fault
`timescale 1ns/1ps
module tpw_pwm_top (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 arst_n_i,
	// ahb-lite slave
	input  wire tpw_pkg::tpw_ahb_req_t ahb_i,
	input  wire logic [31:0]          hwdata_i,
	output logic [31:0]               hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	// pins in
	input  wire logic                 sd_pin_i,
	input  wire logic [2:0]           pos_pin_i,
	// port function of the six pins
	input  wire logic [5:0]           port_out_i,
	input  wire logic [5:0]           port_oe_i,
	// six phase pins
	output logic [5:0]                pin_out_o,
	output logic [5:0]                pin_oe_o,
	// requests
	output logic                      carrier_irq_o,
	output logic                      nmi_req_o
);
	import tpw_pkg::*;

	// bus state
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        addr_ok;
	logic [31:0] next_rdata;
	logic        wr_ctrl;
	logic        wr_outl;
	logic        wr_psel;

	// control
	logic        motor_timer_function_bit;
	logic        phase_output_enable;
	logic        conduction_prevent_select;
	logic        conduction_detect_flag;
	logic        active_level_select;
	logic        capture_polarity_bit;
	logic        forced_cutoff_enable;
	logic        nonmaskable_irq_enable;
	logic        run;
	logic [2:0]  shutdown_filter_setting;
	logic [5:0]  pin_function_select_reg;
	logic        pin_select_protect_bit;
	logic [5:0]  first_output_logic;
	logic [5:0]  second_output_logic;
	logic [15:0] carrier_timer;
	logic [15:0] phase_width_primary [3];
	logic [3:0]  carrier_irq_frequency;

	// datapath state
	logic        sd_f;
	logic        sd_f_d;
	logic [15:0] car_cnt;
	logic        uf;
	logic [3:0]  irq_cnt;
	logic        xfer_pend;
	logic [5:0]  cur;
	logic [2:0]  alt;
	logic [2:0]  done;
	logic [2:0]  both;
	logic        cond_hit;
	logic        oe_kill;
	logic        oe_block;
	logic        hz_all;
	logic [5:0]  pwm_sel;
	logic [5:0]  next_pin_out;
	logic [5:0]  next_pin_oe;
	logic [2:0]  pos_s1;
	logic [2:0]  pos_s2;
	logic [2:0]  position_retained;
	logic [2:0]  hs_lvl;
	logic [2:0]  hs_d;
	logic [2:0]  cap;
	logic        rise_sel;

	// ahb-lite: zero wait states, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign addr_ok = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok && ahb_i.hwrite;
			wr_addr <= ahb_i.haddr[7:0];
		end
	end

	assign wr_ctrl = wr_pend && wr_addr == TPW_A_CTRL;
	assign wr_outl = wr_pend && wr_addr == TPW_A_OUTL;
	assign wr_psel = wr_pend && wr_addr == TPW_A_PSEL;

	// read data is taken in the address phase; unmapped reads give zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (ahb_i.haddr[7:0])
			TPW_A_CTRL: begin
				next_rdata[TPW_B_MTF]  = motor_timer_function_bit;
				next_rdata[TPW_B_OE]   = phase_output_enable;
				next_rdata[TPW_B_CPS]  = conduction_prevent_select;
				next_rdata[TPW_B_CDF]  = conduction_detect_flag;
				next_rdata[TPW_B_ALS]  = active_level_select;
				next_rdata[TPW_B_POL]  = capture_polarity_bit;
				next_rdata[TPW_B_FCE]  = forced_cutoff_enable;
				next_rdata[TPW_B_NMIE] = nonmaskable_irq_enable;
				next_rdata[TPW_B_RUN]  = run;
				next_rdata[TPW_B_FLT +: 3] = shutdown_filter_setting;
			end
			TPW_A_OUTL: begin
				next_rdata[5:0] = first_output_logic;
				next_rdata[TPW_B_OUTL2 +: 6] = second_output_logic;
			end
			TPW_A_PSEL: next_rdata[5:0] = pin_function_select_reg;
			TPW_A_PROT: next_rdata[0] = pin_select_protect_bit;
			TPW_A_CARR: next_rdata[15:0] = carrier_timer;
			TPW_A_WIDU: next_rdata[15:0] = phase_width_primary[0];
			TPW_A_WIDV: next_rdata[15:0] = phase_width_primary[1];
			TPW_A_WIDW: next_rdata[15:0] = phase_width_primary[2];
			TPW_A_IRQF: next_rdata[3:0] = carrier_irq_frequency;
			// half flag at bit 4 stays zero in mode 0, see (R21)
			TPW_A_STAT: next_rdata[3:0] = {sd_f, position_retained};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			hrdata_o <= 32'h0000_0000;
		else if (addr_ok && !ahb_i.hwrite)
			hrdata_o <= next_rdata;
	end

	// plain control bits
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			motor_timer_function_bit  <= 1'b0;
			conduction_prevent_select <= 1'b0;
			active_level_select       <= 1'b0;
			capture_polarity_bit      <= 1'b0;
			forced_cutoff_enable      <= 1'b0;
			nonmaskable_irq_enable    <= 1'b0;
			run                       <= 1'b0;
			shutdown_filter_setting   <= 3'h0;
		end else if (wr_ctrl) begin
			motor_timer_function_bit  <= hwdata_i[TPW_B_MTF];
			conduction_prevent_select <= hwdata_i[TPW_B_CPS];
			active_level_select       <= hwdata_i[TPW_B_ALS];
			capture_polarity_bit      <= hwdata_i[TPW_B_POL];
			forced_cutoff_enable      <= hwdata_i[TPW_B_FCE];
			nonmaskable_irq_enable    <= hwdata_i[TPW_B_NMIE];
			run                       <= hwdata_i[TPW_B_RUN];
			shutdown_filter_setting   <= hwdata_i[TPW_B_FLT +: 3];
		end
	end

	// conduction fault: both sides of a phase active together
	always_comb begin
		for (int p = 0; p < 3; p++)
			both[p] = !cur[2*p] && !cur[2*p+1];
	end
	assign cond_hit = conduction_prevent_select && motor_timer_function_bit
		&& phase_output_enable && (|both); // see (R02)
	assign oe_kill = cond_hit || (motor_timer_function_bit
		&& phase_output_enable && !sd_f); // see (R07)
	assign oe_block = (forced_cutoff_enable && !sd_f) || (|both);

	// enable set is refused during an enabled cutoff or while both sides of a phase are active
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			phase_output_enable <= 1'b0;
		else if (oe_kill)
			phase_output_enable <= 1'b0; // see (R07)
		else if (wr_ctrl)
			phase_output_enable <= hwdata_i[TPW_B_OE] && !oe_block; // see (R24)
	end

	// write one to clear; a fault in the same cycle wins
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			conduction_detect_flag <= 1'b0;
		else if (cond_hit)
			conduction_detect_flag <= 1'b1; // see (R02)
		else if (wr_ctrl && hwdata_i[TPW_B_CDF])
			conduction_detect_flag <= 1'b0;
	end

	// pin selects behind the protect bit
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_select_protect_bit  <= 1'b0;
			pin_function_select_reg <= TPW_PFC_RST;
		end else begin
			if (wr_pend && wr_addr == TPW_A_PROT)
				pin_select_protect_bit <= hwdata_i[0];
			if (wr_psel && pin_select_protect_bit)
				pin_function_select_reg <= hwdata_i[5:0]; // see (R05)
		end
	end

	// timing registers; the secondary width does not exist in mode 0
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			carrier_timer         <= TPW_CARR_RST;
			carrier_irq_frequency <= 4'h0;
			for (int p = 0; p < 3; p++)
				phase_width_primary[p] <= TPW_WID_RST;
		end else if (wr_pend) begin
			if (wr_addr == TPW_A_CARR)
				carrier_timer <= hwdata_i[15:0];
			if (wr_addr == TPW_A_IRQF)
				carrier_irq_frequency <= hwdata_i[3:0];
			if (wr_addr == TPW_A_WIDU)
				phase_width_primary[0] <= hwdata_i[15:0];
			if (wr_addr == TPW_A_WIDV)
				phase_width_primary[1] <= hwdata_i[15:0];
			if (wr_addr == TPW_A_WIDW)
				phase_width_primary[2] <= hwdata_i[15:0];
		end
	end

	// carrier timer: reload on each underflow, one half period each
	assign uf = run && car_cnt == 16'h0000;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			car_cnt <= TPW_CARR_RST;
		else if (!run || uf)
			car_cnt <= carrier_timer; // see (R17)
		else
			car_cnt <= car_cnt - 16'h0001;
	end

	// interrupt every nth underflow; n of zero counts as one
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_cnt       <= 4'h0;
			carrier_irq_o <= 1'b0;
		end else if (uf && (irq_cnt + 4'h1 >= carrier_irq_frequency)) begin
			irq_cnt       <= 4'h0;
			carrier_irq_o <= 1'b1; // see (R19)
		end else begin
			irq_cnt       <= uf ? irq_cnt + 4'h1 : irq_cnt;
			carrier_irq_o <= 1'b0;
		end
	end

	// phase timers started by the carrier underflow
	for (genvar p = 0; p < 3; p++) begin : g_phase
		tpw_oneshot #(.W(16)) u_shot (
			.sys_clk_i (sys_clk_i),
			.arst_n_i  (arst_n_i),
			.trig_i    (uf),
			.width_i   (phase_width_primary[p]),
			.done_o    (done[p])
		);
	end

	// output logic: first after transfer, then alternating per pulse end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			first_output_logic  <= TPW_OUTL_RST;
			second_output_logic <= TPW_OUTL_RST;
			xfer_pend           <= 1'b0;
		end else if (wr_outl) begin
			first_output_logic  <= hwdata_i[5:0];
			second_output_logic <= hwdata_i[TPW_B_OUTL2 +: 6];
			xfer_pend           <= 1'b1;
		end else if (uf) begin
			xfer_pend <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur <= TPW_OUTL_RST;
			alt <= 3'h0;
		end else if (uf && xfer_pend) begin
			cur <= first_output_logic;
			alt <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (done[p]) begin
					alt[p] <= !alt[p];
					cur[2*p +: 2] <= alt[p] ? first_output_logic[2*p +: 2]
						: second_output_logic[2*p +: 2];
				end
			end
		end
	end

	// pin mux; a cutoff floats pins whatever their use
	tpw_sd_filter u_filter (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.sd_pin_i  (sd_pin_i),
		.setting_i (shutdown_filter_setting),
		.level_o   (sd_f)
	);

	assign hz_all = (forced_cutoff_enable && !sd_f)
		|| conduction_detect_flag; // see (R09)
	assign pwm_sel = {6{motor_timer_function_bit && phase_output_enable}}
		& pin_function_select_reg; // see (R03)

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (hz_all) begin
				next_pin_out[i] = 1'b0; // see (R08)
				next_pin_oe[i]  = 1'b0;
			end else if (pwm_sel[i]) begin
				next_pin_out[i] = active_level_select ? !cur[i] : cur[i]; // see (R01)
				next_pin_oe[i]  = 1'b1;
			end else begin
				next_pin_out[i] = port_out_i[i]; // see (R04)
				next_pin_oe[i]  = port_oe_i[i];
			end
		end
	end

	// registered so all six pins switch on the same edge
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_o <= 6'h00;
			pin_oe_o  <= 6'h00;
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_o  <= next_pin_oe;
		end
	end

	// nmi request on a filtered falling shutdown edge
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sd_f_d    <= TPW_SD_RST;
			nmi_req_o <= 1'b0;
		end else begin
			sd_f_d    <= sd_f;
			nmi_req_o <= nonmaskable_irq_enable && sd_f_d && !sd_f; // see (R13)
		end
	end

	// position capture on the chosen high-side edge
	assign rise_sel = capture_polarity_bit ^ active_level_select; // see (R16)
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			hs_lvl[p] = active_level_select ? !cur[2*p] : cur[2*p];
			cap[p] = rise_sel ? (hs_lvl[p] && !hs_d[p])
				: (!hs_lvl[p] && hs_d[p]); // see (R15)
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos_s1            <= 3'h0;
			pos_s2            <= 3'h0;
			// idle high-side level after reset, so no false edge follows it
			hs_d              <= 3'h7;
			position_retained <= 3'h0;
		end else begin
			pos_s1 <= pos_pin_i;
			pos_s2 <= pos_s1;
			hs_d   <= hs_lvl;
			for (int p = 0; p < 3; p++)
				if (cap[p])
					position_retained[p] <= pos_s2[p]; // see (R14)
		end
	end

	// checks
	property p_pin_map;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(!hz_all && pwm_sel[0]) |=> pin_oe_o[0]
			&& pin_out_o[0] == ($past(active_level_select) ^ $past(cur[0]));
	endproperty
	a_pin_map: assert property (p_pin_map) // see (R01)
		else $error("pwm pin level wrong");

	property p_cond;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		cond_hit |=> conduction_detect_flag && !phase_output_enable
			##1 pin_oe_o == 6'h00;
	endproperty
	a_cond: assert property (p_cond) // see (R02)
		else $error("conduction fault not handled");

	property p_gate;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(!hz_all && !pwm_sel[3]) |=> pin_out_o[3] == $past(port_out_i[3])
			&& pin_oe_o[3] == $past(port_oe_i[3]);
	endproperty
	a_gate: assert property (p_gate) // see (R03)
		else $error("unselected pin not at port");

	property p_protect;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(wr_psel && !pin_select_protect_bit) |=> $stable(pin_function_select_reg);
	endproperty
	a_protect: assert property (p_protect) // see (R05)
		else $error("pin select written while protected");

	property p_sd_kill;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(motor_timer_function_bit && phase_output_enable && !sd_f)
			|=> !phase_output_enable;
	endproperty
	a_sd_kill: assert property (p_sd_kill) // see (R07)
		else $error("shutdown did not clear enable");

	property p_cutoff;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(forced_cutoff_enable && !sd_f) |=> pin_oe_o == 6'h00;
	endproperty
	a_cutoff: assert property (p_cutoff) // see (R09)
		else $error("cutoff pins still driven");

	property p_capture;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		cap[1] |=> position_retained[1] == $past(pos_s2[1]);
	endproperty
	a_capture: assert property (p_capture) // see (R14)
		else $error("position not captured");

	property p_reload;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(uf && $stable(carrier_timer)) |=> car_cnt == $past(carrier_timer);
	endproperty
	a_reload: assert property (p_reload) // see (R17)
		else $error("carrier reload wrong");

	property p_irq;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		carrier_irq_o |-> $past(uf);
	endproperty
	a_irq: assert property (p_irq) // see (R19)
		else $error("irq without underflow");

	property p_refuse;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(wr_ctrl && forced_cutoff_enable && !sd_f) |=> !phase_output_enable;
	endproperty
	a_refuse: assert property (p_refuse) // see (R24)
		else $error("enable set during cutoff");

endmodule : tpw_pwm_top

// ---- tb/tpw_gate_model.sv ----
/*
 * tpw_gate_model: gate driver and board side of the shutdown and position pins.
 * assumes the bench commands a fault; the board pull-up holds sd high.
 */
`timescale 1ns/1ps
module tpw_gate_model (
	// fault command and hall code from the bench
	input  wire logic       fault_i,
	input  wire logic [2:0] hall_i,
	// pins toward the block
	output logic            sd_pin_o,
	output logic [2:0]      pos_pin_o
);
	// pulled high unless a fault pulls it down
	assign sd_pin_o  = ~fault_i;
	assign pos_pin_o = hall_i;
endmodule : tpw_gate_model

// ---- tb/test_tpw_pwm_top.sv ----
/*
 * test_tpw_pwm_top: directed bench for the pwm output stage.
 * assumes a zero-wait ahb-lite slave and the package register map.
 */
`timescale 1ns/1ps
module test_tpw_pwm_top;
	import tpw_pkg::*;
	logic          sys_clk, arst_n, rdy, fault, sd, nmi, irq, resp;
	tpw_ahb_req_t  ahb, ahb_w;
	logic [31:0]   hwdata, hrdata, q;
	logic [5:0]    port_out, port_oe, pin_out, pin_oe;
	logic [2:0]    pos, hall;
	int            mismatches, compares, cyc, n_irq, n_nmi;
	// slave hreadyout is the bus hready
	assign ahb_w = {ahb[39:1], rdy};
	tpw_gate_model gm_u (.fault_i(fault), .hall_i(hall), .sd_pin_o(sd),
		.pos_pin_o(pos));
	tpw_pwm_top dut_u (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.ahb_i(ahb_w), .hwdata_i(hwdata), .hrdata_o(hrdata),
		.hreadyout_o(rdy), .hresp_o(resp), .sd_pin_i(sd), .pos_pin_i(pos),
		.port_out_i(port_out), .port_oe_i(port_oe), .pin_out_o(pin_out),
		.pin_oe_o(pin_oe), .carrier_irq_o(irq), .nmi_req_o(nmi));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		ahb <= '{1'b1, {24'h0, a}, 2'h2, w, 3'h2, 1'b1};
		@(posedge sys_clk);
		while (rdy !== 1'b1) @(posedge sys_clk);
		ahb.htrans <= 2'h0;
		hwdata     <= d;
		@(posedge sys_clk);
		while (rdy !== 1'b1) @(posedge sys_clk);
		q = hrdata;
		chk(resp, 32'h0);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	task automatic settle;
		n_irq = 0;
		n_nmi = 0;
		repeat (20) begin
			@(posedge sys_clk);
			n_irq += irq;
			n_nmi += nmi;
		end
	endtask : settle
	task automatic t_protect;
		bus(1'b1, TPW_A_PSEL, 32'h15);
		rd(TPW_A_PSEL, 32'h3F);
		bus(1'b1, TPW_A_PROT, 32'h1);
		bus(1'b1, TPW_A_PSEL, 32'h15);
		bus(1'b1, TPW_A_PROT, 32'h0);
		rd(TPW_A_PSEL, 32'h15);
	endtask : t_protect
	task automatic t_output;
		bus(1'b1, TPW_A_CARR, 32'h4);
		bus(1'b1, TPW_A_IRQF, 32'h2);
		bus(1'b1, TPW_A_OUTL, 32'h2A2A);
		bus(1'b1, TPW_A_CTRL, 32'h103);
		settle();
		chk(pin_out, 6'h2A);
		chk(pin_oe, 6'h3F);
		rd(TPW_A_STAT, 32'hD);
		hall <= 3'h2;
		settle();
		chk(n_irq, 2);
		rd(TPW_A_STAT, 32'hD);
		bus(1'b1, TPW_A_CTRL, 32'h113);
		settle();
		chk(pin_out, 6'h3F);
	endtask : t_output
	task automatic t_cutoff;
		bus(1'b1, TPW_A_CTRL, 32'h343);
		fault <= 1'b1;
		settle();
		chk(pin_oe, 6'h00);
		chk(n_nmi, 0);
		rd(TPW_A_CTRL, 32'h341);
		bus(1'b1, TPW_A_CTRL, 32'h143);
		rd(TPW_A_CTRL, 32'h141);
		fault <= 1'b0;
		settle();
		bus(1'b1, TPW_A_CTRL, 32'h143);
		rd(TPW_A_CTRL, 32'h143);
		bus(1'b1, TPW_A_CTRL, 32'h183);
		fault <= 1'b1;
		settle();
		chk(pin_oe, 6'h3F);
		chk(pin_out, 6'h3F);
		chk(n_nmi, 1);
		rd(TPW_A_CTRL, 32'h181);
		fault <= 1'b0;
		settle();
	endtask : t_cutoff
	task automatic t_conduct;
		bus(1'b1, TPW_A_CTRL, 32'h107);
		bus(1'b1, TPW_A_OUTL, 32'h0);
		settle();
		rd(TPW_A_CTRL, 32'h10D);
		chk(pin_oe, 6'h00);
	endtask : t_conduct
	initial begin
		arst_n   = 1'b0;
		ahb      = '0;
		hwdata   = '0;
		fault    = 1'b0;
		hall     = 3'h5;
		port_out = 6'h3F;
		port_oe  = 6'h3F;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_protect();
		t_output();
		t_cutoff();
		t_conduct();
		end_of_test();
	end
endmodule : test_tpw_pwm_top
